// ==== aux_io_digital_analog_mapper.v ====
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "aux_io_map.vh"
module aux_io_digital_analog_mapper #(
  parameter MS_CYCLES     = `CLK_HZ / `MS_PER_S,
  parameter SAMPLE_CYCLES = `CLK_HZ / `SAMPLE_RATE_HZ
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  input  wire         user_digital_input_one,
  input  wire         user_digital_input_two,
  input  wire         user_digital_input_three,
  input  wire         output_enabled,
  input  wire         form_single,
  input  wire         fault_active,
  input  wire         transient_active,
  input  wire         program_active,
  input  wire         remote_mode,
  input  wire         transformer_coupled_indicator,
  output wire         user_digital_output_one,
  output wire         user_digital_output_two,
  input  wire         relay_drive_out_a_in,
  output wire         relay_drive_out_a_out,
  output wire         relay_drive_out_a_oe,
  input  wire         relay_drive_out_b_in,
  output wire         relay_drive_out_b_out,
  output wire         relay_drive_out_b_oe,
  output reg          action_strobe,
  output reg  [7:0]   action_code,
  output reg  [1:0]   action_channel,
  output reg          action_on_rise,
  input  wire [63:0]  ain_mv,
  input  wire [127:0] meas,
  output reg  [127:0] param_value,
  output reg  [3:0]   param_update,
  output wire [11:0]  param_target,
  output wire [7:0]   param_phase,
  output wire [15:0]  analog_monitor_out_one,
  output wire [15:0]  analog_monitor_out_two,
  output wire [15:0]  analog_monitor_out_three,
  output wire [15:0]  analog_monitor_out_four
);
  localparam [16:0] MS_LAST  = MS_CYCLES[16:0] - 17'h1;
  localparam [22:0] SMP_LAST = SAMPLE_CYCLES[22:0] - 23'h1;
  localparam [3:0]  ST_IDLE  = 4'b0001;
  localparam [3:0]  ST_START = 4'b0010;
  localparam [3:0]  ST_WAIT  = 4'b0100;
  localparam [3:0]  ST_STORE = 4'b1000;

  reg        [23:0] filt_ms   [0:2];
  reg        [15:0] din_act   [0:2];
  reg        [5:0]  dout_cfg  [0:3];
  reg        [2:0]  ain_par   [0:3];
  reg        [1:0]  ain_ph    [0:3];
  reg        [15:0] ain_fs    [0:3];
  reg signed [31:0] ain_gain  [0:3];
  reg signed [31:0] ain_ofs   [0:3];
  reg signed [31:0] ain_res   [0:3];
  reg        [1:0]  aout_sel  [0:3];
  reg signed [31:0] aout_gain [0:3];
  reg signed [31:0] aout_ofs  [0:3];
  reg        [15:0] aout_lvl  [0:3];
  reg        [3:0]  dlev;
  reg        [5:0]  evt;
  reg        [5:0]  pend;
  reg        [16:0] ms_cnt;
  reg        [22:0] smp_cnt;
  reg               ms_tick;
  reg               smp_tick;
  reg        [3:0]  state;
  reg        [2:0]  job;
  reg        [31:0] rd_mux;
  reg        [5:0]  grant;
  reg signed [15:0] vin;
  reg signed [15:0] fs_s;
  reg signed [32:0] diff;
  reg signed [47:0] num;
  reg        [31:0] den;
  reg signed [48:0] sum;
  wire       [2:0]  din_raw = {user_digital_input_three, user_digital_input_two,
                               user_digital_input_one};
  wire       [2:0]  din_lvl;
  wire       [2:0]  din_rise;
  wire       [2:0]  din_fall;
  wire              div_done;
  wire signed [47:0] quot;
  wire       [3:0]  grp = paddr[7:4];
  wire       [1:0]  idx = paddr[3:2];
  wire       [1:0]  jl = job[1:0];
  wire              apb_done = psel & penable & pready;
  wire              wr = apb_done & pwrite & reg_ok(paddr);
  integer           i, gi, ei, fi;

  function reg_ok;
    input [11:0] a;
    begin
      if (a[11:8] != 4'h0 || a[1:0] != 2'b00 || a[7:4] > `GRP_AOUT_LVL)
        reg_ok = 1'b0;
      else if (a[7:4] == `GRP_STATUS)
        reg_ok = (a[3:2] < 2'h2);
      else if (a[7:4] == `GRP_DIN_FILT || a[7:4] == `GRP_DIN_ACT)
        reg_ok = (a[3:2] < 2'h3);
      else
        reg_ok = 1'b1;
    end
  endfunction

  function signed [31:0] par_max;
    input [2:0] p;
    begin
      case (p)
        `PAR_VAC:  par_max = `VAC_MAX;
        `PAR_VDC:  par_max = `VDC_MAX;
        `PAR_FREQ: par_max = `FREQ_MAX;
        default:   par_max = `GEN_MAX;
      endcase
    end
  endfunction

  function signed [31:0] par_min;
    input [2:0] p;
    begin
      case (p)
        `PAR_VDC:  par_min = `VDC_MIN;
        `PAR_FREQ: par_min = `FREQ_MIN;
        default:   par_min = 32'h0000_0000;
      endcase
    end
  endfunction

  // Frequency keeps its floor as offset so that 0 V still means 15 Hz
  function signed [31:0] dflt_ofs;
    input [2:0] p;
    begin
      dflt_ofs = (p == `PAR_FREQ) ? `FREQ_MIN : 32'h0000_0000;
    end
  endfunction

  function dout_src;
    input [5:0] c;
    begin
      case (c[`DOUT_FN_MSB:0])
        `FN_HIGH:      dout_src = 1'b1;
        `FN_LEVEL:     dout_src = c[`DOUT_LVL_BIT];
        `FN_OUT_STATE: dout_src = output_enabled;
        `FN_FORM:      dout_src = form_single;
        `FN_FAULT:     dout_src = fault_active;
        `FN_TRANSIENT: dout_src = transient_active;
        `FN_PROGRAM:   dout_src = program_active;
        `FN_REMOTE:    dout_src = remote_mode;
        `FN_COUPLING:  dout_src = transformer_coupled_indicator;
        default:       dout_src = 1'b0;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : din
      din_filter u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (din_raw[g]),
        .ms_tick (ms_tick),
        .filt_ms (filt_ms[g]),
        .level   (din_lvl[g]),
        .rise    (din_rise[g]),
        .fall    (din_fall[g])
      );
    end
  endgenerate

  serial_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (state == ST_START),
    .num     (num),
    .den     (den),
    .done    (div_done),
    .quot    (quot)
  );

  // Relay drives are open drain: a one turns the FET on and pulls the pin low; user outputs drive dlev directly
  assign user_digital_output_one  = dlev[0];
  assign user_digital_output_two  = dlev[1];
  assign relay_drive_out_a_out    = 1'b0;
  assign relay_drive_out_a_oe     = dlev[2];
  assign relay_drive_out_b_out    = 1'b0;
  assign relay_drive_out_b_oe     = dlev[3];
  assign analog_monitor_out_one   = aout_lvl[0];
  assign analog_monitor_out_two   = aout_lvl[1];
  assign analog_monitor_out_three = aout_lvl[2];
  assign analog_monitor_out_four  = aout_lvl[3];
  assign param_target = {ain_par[3], ain_par[2], ain_par[1], ain_par[0]};
  assign param_phase  = {ain_ph[3], ain_ph[2], ain_ph[1], ain_ph[0]};

  always @* begin
    rd_mux = 32'h0;
    case (grp)
      `GRP_STATUS:
        if (idx == 2'h0)
          rd_mux = {22'h0, relay_drive_out_b_in, relay_drive_out_a_in, dlev, 1'b0, din_lvl};
        else
          rd_mux = {26'h0, evt};
      `GRP_DIN_FILT: rd_mux = {8'h0, filt_ms[idx]};
      `GRP_DIN_ACT:  rd_mux = {16'h0, din_act[idx]};
      `GRP_DOUT_CFG: rd_mux = {26'h0, dout_cfg[idx]};
      `GRP_AIN_CFG:  rd_mux = {ain_fs[idx], 10'h0, ain_ph[idx], 1'b0, ain_par[idx]};
      `GRP_AIN_GAIN: rd_mux = ain_gain[idx];
      `GRP_AIN_OFS:  rd_mux = ain_ofs[idx];
      `GRP_AIN_RES:  rd_mux = ain_res[idx];
      `GRP_AOUT_SEL: rd_mux = {30'h0, aout_sel[idx]};
      `GRP_AOUT_GAIN: rd_mux = aout_gain[idx];
      `GRP_AOUT_OFS: rd_mux = aout_ofs[idx];
      `GRP_AOUT_LVL: rd_mux = {16'h0, aout_lvl[idx]};
      default:       rd_mux = 32'h0;
    endcase
  end

  // One wait state keeps every bus output on a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~reg_ok(paddr);
      prdata  <= (psel & ~pwrite & reg_ok(paddr)) ? rd_mux : 32'h0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (i < 3) begin
          filt_ms[i] <= 24'h0;
          din_act[i] <= 16'h0;
        end
        dout_cfg[i]  <= 6'h0;
        ain_par[i]   <= `PAR_OFF;
        ain_ph[i]    <= 2'h0;
        ain_fs[i]    <= `AIN_FS_RST;
        ain_gain[i]  <= 32'h0000_0000;
        ain_ofs[i]   <= 32'h0000_0000;
        aout_sel[i]  <= i[1:0];
        aout_gain[i] <= (i == 3) ? `AOUT_PWR_GAIN : `VAC_MAX;
        aout_ofs[i]  <= 32'h0000_0000;
      end
    end else if (wr) begin
      case (grp)
        `GRP_DIN_FILT: filt_ms[idx] <= pwdata[23:0];
        `GRP_DIN_ACT:  din_act[idx] <= pwdata[15:0];
        `GRP_DOUT_CFG: dout_cfg[idx] <= pwdata[5:0];
        `GRP_AIN_CFG: begin
          ain_par[idx] <= pwdata[`AIN_PAR_MSB:0];
          ain_ph[idx]  <= pwdata[`AIN_PH_LSB+1:`AIN_PH_LSB];
          if (pwdata[31:`AIN_FS_LSB] < `AIN_FS_MIN)
            ain_fs[idx] <= `AIN_FS_MIN;
          else if (pwdata[31:`AIN_FS_LSB] > `AIN_FS_MAX)
            ain_fs[idx] <= `AIN_FS_MAX;
          else
            ain_fs[idx] <= pwdata[31:`AIN_FS_LSB];
          if (pwdata[`AIN_PAR_MSB:0] != ain_par[idx]) begin
            ain_ofs[idx]  <= dflt_ofs(pwdata[`AIN_PAR_MSB:0]);
            ain_gain[idx] <= par_max(pwdata[`AIN_PAR_MSB:0])
                             - dflt_ofs(pwdata[`AIN_PAR_MSB:0]);
          end
        end
        `GRP_AIN_GAIN: ain_gain[idx] <= pwdata;
        `GRP_AIN_OFS:  ain_ofs[idx] <= pwdata;
        `GRP_AOUT_SEL: aout_sel[idx] <= pwdata[1:0];
        `GRP_AOUT_GAIN: aout_gain[idx] <= pwdata;
        `GRP_AOUT_OFS: aout_ofs[idx] <= pwdata;
        default: ;
      endcase
    end
  end

  always @* begin
    grant = 6'h0;
    for (gi = 5; gi >= 0; gi = gi - 1)
      if (pend[gi])
        grant = 6'h1 << gi;
  end

  // Edge flags and pending actions; a new edge wins over a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt            <= 6'h0;
      pend           <= 6'h0;
      dlev           <= 4'h0;
      ms_cnt         <= 17'h0;
      ms_tick        <= 1'b0;
      action_strobe  <= 1'b0;
      action_code    <= 8'h0;
      action_channel <= 2'h0;
      action_on_rise <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == MS_LAST);
      ms_cnt  <= (ms_cnt == MS_LAST) ? 17'h0 : ms_cnt + 17'h1;
      for (ei = 0; ei < 4; ei = ei + 1)
        dlev[ei] <= dout_src(dout_cfg[ei]) ^ dout_cfg[ei][`DOUT_INV_BIT];
      evt <= (evt & ~((wr && paddr == `OFS_EVENT) ? pwdata[5:0] : 6'h0))
             | {din_fall, din_rise};
      pend <= (pend & ~grant) | {din_fall, din_rise};
      action_strobe <= |grant;
      for (ei = 0; ei < 6; ei = ei + 1)
        if (grant[ei]) begin
          action_channel <= (ei < 3) ? ei[1:0] : ei[1:0] - 2'h3;
          action_on_rise <= (ei < 3);
          action_code <= (ei < 3) ? din_act[ei % 3][7:0] : din_act[ei % 3][15:8];
        end
    end
  end

  // Jobs 0..3 are analog inputs, 4..7 are monitor outputs
  always @* begin
    fs_s = ain_fs[jl];
    vin  = ain_mv[jl*16 +: 16];
    if (ain_par[jl] != `PAR_VDC && vin < 0)
      vin = 16'h0000;
    if (vin > fs_s)
      vin = fs_s;
    if (vin < -fs_s)
      vin = -fs_s;
    diff = $signed(meas[aout_sel[jl]*32 +: 32]) - aout_ofs[jl];
    if (!job[2]) begin
      num = vin * ain_gain[jl];
      den = {16'h0, ain_fs[jl]};
    end else begin
      num = diff * $signed({1'b0, `AOUT_FS_MV});
      den = (aout_gain[jl] > 0) ? aout_gain[jl] : 32'h0000_0001;
    end
    sum = quot + ain_ofs[jl];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_IDLE;
      job          <= 3'h0;
      smp_cnt      <= 23'h0;
      smp_tick     <= 1'b0;
      param_update <= 4'h0;
      param_value  <= 128'h0;
      for (fi = 0; fi < 4; fi = fi + 1) begin
        ain_res[fi]  <= 32'h0000_0000;
        aout_lvl[fi] <= 16'h0000;
      end
    end else begin
      smp_tick     <= (smp_cnt == SMP_LAST);
      smp_cnt      <= (smp_cnt == SMP_LAST) ? 23'h0 : smp_cnt + 23'h1;
      param_update <= 4'h0;
      case (state)
        ST_IDLE:
          if (smp_tick) begin
            job   <= 3'h0;
            state <= ST_START;
          end
        ST_START: state <= ST_WAIT;
        ST_WAIT:  if (div_done) state <= ST_STORE;
        ST_STORE: begin
          if (!job[2] && ain_par[jl] != `PAR_OFF) begin
            if (sum > par_max(ain_par[jl]))
              ain_res[jl] <= par_max(ain_par[jl]);
            else if (sum < par_min(ain_par[jl]))
              ain_res[jl] <= par_min(ain_par[jl]);
            else
              ain_res[jl] <= sum[31:0];
            param_value[jl*32 +: 32] <= (sum > par_max(ain_par[jl])) ? par_max(ain_par[jl])
                                      : (sum < par_min(ain_par[jl])) ? par_min(ain_par[jl])
                                      : sum[31:0];
            param_update[jl] <= 1'b1;
          end else if (job[2]) begin
            if (aout_gain[jl] <= 0 || quot < 0)
              aout_lvl[jl] <= 16'h0000;
            else if (quot > $signed({1'b0, `AOUT_FS_MV}))
              aout_lvl[jl] <= `AOUT_FS_MV;
            else
              aout_lvl[jl] <= quot[15:0];
          end
          job   <= job + 3'h1;
          state <= (job == 3'h7) ? ST_IDLE : ST_START;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== aux_io_map.vh ====
`ifndef AUX_IO_MAP_VH
`define AUX_IO_MAP_VH

// Register byte offsets and register groups (address bits 7:4)
`define OFS_STATUS     12'h000
`define OFS_EVENT      12'h004
`define GRP_STATUS     4'h0
`define GRP_DIN_FILT   4'h1
`define GRP_DIN_ACT    4'h2
`define GRP_DOUT_CFG   4'h3
`define GRP_AIN_CFG    4'h4
`define GRP_AIN_GAIN   4'h5
`define GRP_AIN_OFS    4'h6
`define GRP_AIN_RES    4'h7
`define GRP_AOUT_SEL   4'h8
`define GRP_AOUT_GAIN  4'h9
`define GRP_AOUT_OFS   4'ha
`define GRP_AOUT_LVL   4'hb

// Digital output config fields
`define DOUT_FN_MSB    3
`define DOUT_INV_BIT   4
`define DOUT_LVL_BIT   5
`define FN_LOW         4'h0
`define FN_HIGH        4'h1
`define FN_LEVEL       4'h2
`define FN_OUT_STATE   4'h3
`define FN_FORM        4'h4
`define FN_FAULT       4'h5
`define FN_TRANSIENT   4'h6
`define FN_PROGRAM     4'h7
`define FN_REMOTE      4'h8
`define FN_COUPLING    4'h9

// Analog input config fields and targets
`define AIN_PAR_MSB    2
`define AIN_PH_LSB     4
`define AIN_FS_LSB     16
`define PAR_OFF        3'h0
`define PAR_VAC        3'h1
`define PAR_VDC        3'h2
`define PAR_CURR       3'h3
`define PAR_FREQ       3'h4
`define PAR_KVA        3'h5
`define PAR_POW        3'h6

// Scaling values, milli-units
`define VAC_MAX        32'h0006_B6C0
`define VDC_MAX        32'h0009_EB10
`define VDC_MIN        32'hFFF6_14F0
`define FREQ_MIN       32'h0000_3A98
`define FREQ_MAX       32'h000F_4240
`define GEN_MAX        32'h0001_86A0
`define AOUT_PWR_GAIN  32'h0001_86A0
`define AIN_FS_MIN     16'h03E8
`define AIN_FS_MAX     16'h2710
`define AIN_FS_RST     16'h2710
`define AOUT_FS_MV     16'h1388

// Timing
`define CLK_HZ         125000000
`define MS_PER_S       1000
`define SAMPLE_RATE_HZ 20
`define DIV_STEPS      6'h30

`endif

// ==== din_filter.v ====
`timescale 1ns/10ps
`include "aux_io_map.vh"
module din_filter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        raw,
  input  wire        ms_tick,
  input  wire [23:0] filt_ms,
  output reg         level,
  output reg         rise,
  output reg         fall
);
  reg [23:0] cnt;

  // A change is accepted only once it has held for the set time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
      cnt   <= 24'h0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (raw == level) begin
        cnt <= 24'h0;
      end else if (cnt >= filt_ms) begin
        level <= raw;
        cnt   <= 24'h0;
        rise  <= raw;
        fall  <= ~raw;
      end else if (ms_tick) begin
        cnt <= cnt + 24'h1;
      end
    end
  end
endmodule

// ==== serial_divider.v ====
`timescale 1ns/10ps
`include "aux_io_map.vh"
module serial_divider (
  input  wire               pclk,
  input  wire               presetn,
  input  wire               start,
  input  wire signed [47:0] num,
  input  wire        [31:0] den,
  output reg                done,
  output reg  signed [47:0] quot
);
  reg [47:0] q;
  reg [32:0] rem;
  reg [31:0] d;
  reg [5:0]  cnt;
  reg        neg;
  reg        busy;
  wire [32:0] trial = {rem[31:0], q[47]} - {1'b0, d};

  // Restoring division on magnitudes; divisor must stay below 2^31
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q    <= 48'h0;
      rem  <= 33'h0;
      d    <= 32'h0;
      cnt  <= 6'h0;
      neg  <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      quot <= 48'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        q    <= num[47] ? -num : num;
        neg  <= num[47];
        rem  <= 33'h0;
        d    <= den;
        cnt  <= `DIV_STEPS;
        busy <= 1'b1;
      end else if (busy && cnt != 6'h0) begin
        cnt <= cnt - 6'h1;
        if (!trial[32]) begin
          rem <= trial;
          q   <= {q[46:0], 1'b1};
        end else begin
          rem <= {rem[31:0], q[47]};
          q   <= {q[46:0], 1'b0};
        end
      end else if (busy) begin
        busy <= 1'b0;
        done <= 1'b1;
        quot <= neg ? -q : q;
      end
    end
  end
endmodule

// ==== aux_io_props_properties.sv ====
`timescale 1ns/10ps
module aux_io_props (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         action_strobe,
  input wire logic [7:0]   action_code,
  input wire logic [1:0]   action_channel,
  input wire logic         action_on_rise,
  input wire logic         relay_drive_out_a_out,
  input wire logic         relay_drive_out_b_out,
  input wire logic [127:0] param_value,
  input wire logic [3:0]   param_update,
  input wire logic [15:0]  analog_monitor_out_one,
  input wire logic [15:0]  analog_monitor_out_four
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ACTION_CHANNEL: assert property (action_strobe |-> action_channel != 2'h3)
    else $error("action channel out of range");
  AST_ACTION_HOLD: assert property (!action_strobe |->
    $stable({action_code, action_channel, action_on_rise}))
    else $error("action fields moved without strobe");
  AST_OPEN_DRAIN: assert property (!relay_drive_out_a_out && !relay_drive_out_b_out)
    else $error("open drain output driven high");
  AST_MON_RANGE: assert property (analog_monitor_out_one <= 16'h1388 &&
    analog_monitor_out_four <= 16'h1388)
    else $error("monitor level above range");
  AST_UPDATE_PULSE: assert property (param_update != 4'h0 |=> (param_update == 4'h0) [*8])
    else $error("parameter updates too close");
  AST_CLAMP: assert property (param_update[0] |->
    $signed(param_value[31:0]) >= -650000 && $signed(param_value[31:0]) <= 1000000)
    else $error("scaled result outside range");
  cover property (action_strobe && action_on_rise);
  cover property (param_update[0]);
  cover property (pready && pslverr);
endmodule
bind aux_io_digital_analog_mapper aux_io_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .action_strobe(action_strobe), .action_code(action_code),
  .action_channel(action_channel), .action_on_rise(action_on_rise),
  .relay_drive_out_a_out(relay_drive_out_a_out), .relay_drive_out_b_out(relay_drive_out_b_out),
  .param_value(param_value), .param_update(param_update),
  .analog_monitor_out_one(analog_monitor_out_one),
  .analog_monitor_out_four(analog_monitor_out_four));

// ==== ext_equipment.sv ====
`timescale 1ns/10ps
module ext_equipment (
  input  wire logic oe_a,
  input  wire logic oe_b,
  output logic      pin_a,
  output logic      pin_b
);
  // Pull-ups hold the pin high; a FET that is on pulls it low
  assign pin_a = oe_a ? 1'b0 : 1'b1;
  assign pin_b = oe_b ? 1'b0 : 1'b1;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, rerr;
  logic [2:0]   din = 3'h0;
  logic [6:0]   st = 7'h00;
  logic [63:0]  ain = 64'h0;
  logic [127:0] meas = 128'h0;
  logic [127:0] pval;
  logic [3:0]   pupd;
  logic [11:0]  ptgt;
  logic [7:0]   pph;
  logic         stb, rise, oe_a, oe_b, pin_a, pin_b, do1, do2;
  logic [7:0]   code;
  logic [1:0]   chan;
  logic [15:0]  mon1, mon2, mon3, mon4;
  int           err_total = 0;
  int           checks = 0;

  aux_io_digital_analog_mapper #(.MS_CYCLES(4), .SAMPLE_CYCLES(600)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .user_digital_input_one(din[0]), .user_digital_input_two(din[1]),
    .user_digital_input_three(din[2]), .output_enabled(st[0]), .form_single(st[1]),
    .fault_active(st[2]), .transient_active(st[3]), .program_active(st[4]),
    .remote_mode(st[5]), .transformer_coupled_indicator(st[6]),
    .user_digital_output_one(do1), .user_digital_output_two(do2),
    .relay_drive_out_a_in(pin_a), .relay_drive_out_a_out(), .relay_drive_out_a_oe(oe_a),
    .relay_drive_out_b_in(pin_b), .relay_drive_out_b_out(), .relay_drive_out_b_oe(oe_b),
    .action_strobe(stb), .action_code(code), .action_channel(chan),
    .action_on_rise(rise), .ain_mv(ain), .meas(meas), .param_value(pval),
    .param_update(pupd), .param_target(ptgt), .param_phase(pph),
    .analog_monitor_out_one(mon1), .analog_monitor_out_two(mon2),
    .analog_monitor_out_three(mon3), .analog_monitor_out_four(mon4));

  ext_equipment EXT (.oe_a(oe_a), .oe_b(oe_b), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Entered just after an edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic wait_stb(input int lim, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (stb !== 1'b1 && n < lim);
  endtask

  task automatic t_reset();
    int n;
    rdchk(12'h090, 32'h0006_B6C0);
    rdchk(12'h09C, 32'h0001_86A0);
    rdchk(12'h08C, 32'h0000_0003);
    rdchk(12'h044, 32'h2710_0000);
    apb(1'b0, 12'h300, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      if (pupd !== 4'h0) n++;
    end
    chk(n, 0);
  endtask

  task automatic t_din();
    int n;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h020 + 12'(4 * i), 32'h0000_5040 + 32'(i * 32'h0101));
      din[i] <= 1'b1;
      wait_stb(20, n);
      chk({15'h0, rise, 6'h0, chan, code}, 32'h0001_0040 + 32'(i * 32'h0101));
      din[i] <= 1'b0;
      wait_stb(20, n);
      chk({15'h0, rise, 6'h0, chan, code}, 32'h0000_0050 + 32'(i * 32'h0101));
    end
    rdchk(12'h004, 32'h0000_003F);
    apb(1'b1, 12'h004, 32'h0000_003F);
    rdchk(12'h004, 32'h0000_0000);
  endtask

  task automatic t_filter();
    int n;
    apb(1'b1, 12'h014, 32'h0000_0002);
    din[1] <= 1'b1;
    repeat (4) @(posedge pclk);
    din[1] <= 1'b0;
    wait_stb(40, n);
    chk({31'h0, stb}, 32'h0000_0000);
    din[1] <= 1'b1;
    wait_stb(60, n);
    chk({31'h0, stb}, 32'h0000_0001);
    chk(32'(n >= 8), 32'h0000_0001);
    din[1] <= 1'b0;
    wait_stb(60, n);
  endtask

  task automatic t_dout();
    logic [31:0] cfg;
    logic        e;
    int          sh;
    for (int fn = 0; fn < 10; fn++)
      for (int k = 0; k < 4; k++) begin
        sh = (fn > 2) ? fn - 3 : 0;
        cfg = 32'(fn) | (32'(k & 3) << 4);
        st <= (k > 1) ? (7'h01 << sh) : ~(7'h01 << sh);
        e = ((fn == 1) || (fn > 1 && k > 1)) ^ k[0];
        for (int c = 0; c < 4; c++)
          apb(1'b1, 12'h030 + 12'(4 * c), cfg);
        repeat (2) @(posedge pclk);
        chk({28'h0, do1, do2, pin_a, pin_b}, {28'h0, e, e, !e, !e});
      end
    rdchk(12'h000, 32'h0000_0300);
  endtask

  // Two updates, so the first may still belong to the old setting
  task automatic ain_case(input logic [31:0] cfg, input logic [15:0] mv,
                          input logic [31:0] exp);
    int n;
    apb(1'b1, 12'h040, cfg);
    ain[15:0] <= mv;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pupd[0] !== 1'b1 && n < 700);
      chk({31'h0, pupd[0]}, 32'h0000_0001);
    end
    chk(pval[31:0], exp);
    chk({27'h0, pph[1:0], ptgt[2:0]}, {27'h0, cfg[5:4], cfg[2:0]});
  endtask

  task automatic t_ain();
    int n;
    ain_case(32'h2710_0011, 16'h2710, 32'h0006_B6C0);
    rdchk(12'h050, 32'h0006_B6C0);
    ain_case(32'h2710_0004, 16'h0000, 32'h0000_3A98);
    rdchk(12'h050, 32'h000F_07A8);
    ain_case(32'h2710_0002, 16'hD8F0, 32'hFFF6_14F0);
    ain_case(32'h2710_0001, 16'hD8F0, 32'h0000_0000);
    ain_case(32'h1388_0001, 16'h1388, 32'h0006_B6C0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pupd[0] !== 1'b1 && n < 700);
    chk(n, 600);
  endtask

  task automatic t_mon();
    meas <= {32'h0000_C350, 32'h0000_0000, 32'h0007_A120, 32'h0003_5B60};
    repeat (1300) @(posedge pclk);
    chk({mon1, mon2}, {16'h09C4, 16'h1388});
    chk({mon3, mon4}, {16'h0000, 16'h09C4});
    rdchk(12'h0B0, 32'h0000_09C4);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_din();
    t_filter();
    t_dout();
    t_ain();
    t_mon();
    stop_test();
  end

  initial begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule
